// ### acs_pkg.sv
// Package with register map, field layout, timing and types of the ADC sequencer
package acs_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_STAT = 8'h0d;
  localparam logic [7:0] ADDR_RESH = 8'h0e;
  localparam logic [7:0] ADDR_RESL = 8'h0f;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_CONF = 8'h11;
  localparam logic [7:0] ADDR_CMPH = 8'h12;
  localparam logic [7:0] ADDR_REF  = 8'h13;

  // ==========================================================================
  // Field positions
  localparam int CTRL_SINGLE_SHOT_START_BIT  = 7;
  localparam int CTRL_REPEAT_START_BIT  = 6;
  localparam int CHAN_W         = 4;
  localparam int CONF_JUST_BIT  = 5;
  localparam int CONF_HOLD_BIT  = 3;
  localparam int CONF_SR_LSB    = 0;
  localparam int CMPH_EN_BIT    = 7;
  localparam int CMPH_DEC_BIT   = 5;
  localparam int STAT_RDY_BIT   = 0;
  localparam int STAT_CMP_BIT   = 1;
  localparam logic [7:0] CMPH_MASK = 8'he3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CONF_RST = 8'h00;
  localparam logic [7:0] CMPH_RST = 8'h00;
  localparam logic [7:0] REF_RST  = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int PEAK_RATE_KSPS   = 250;
  localparam int T_BASE_NS        = 1000000 / PEAK_RATE_KSPS;
  localparam int BASE_CYC_DEF     = T_BASE_NS / CLK_PERIOD_NS;
  localparam int T_SETTLE_NS      = 10000;
  localparam int SETTLE_CYC_DEF   = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CONV_NS        = 1500;
  localparam int CONV_CYC         = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_IDLE_NS        = 500;
  localparam int IDLE_CYC         = (T_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_TSMP_NS        = 2000;
  localparam int TSMP_CYC         = (T_TSMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] TEMP_MIN_SR = 3'h3;
  localparam logic [CHAN_W-1:0] TEMP_CHAN = 4'hf;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETTLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b011,
    ST_IDLEPH = 3'b100,
    ST_HOLD   = 3'b101
  } acs_state_type;

endpackage

// ### acs_phase_timer.sv
// Down counter that times one sequencer phase
`timescale 1ns/1ps
module acs_phase_timer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Phase control
  input  wire logic        load_i,
  input  wire logic [15:0] len_i,
  output logic             zero_o
);
  import acs_pkg::*;

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  // A length of L keeps zero low for L-1 cycles after the load
  assign cnt_nxt = load_i ? (len_i - 16'd1) : ((cnt_r != 16'd0) ? (cnt_r - 16'd1) : 16'd0);
  assign zero_o  = (cnt_r == 16'd0);

  // Counter register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= 16'd0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // acs_phase_timer

// ### acs_match_counter.sv
// Counter of comparator matches against a reference count; a miss restarts it or steps it down
`timescale 1ns/1ps
module acs_match_counter (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Per conversion comparator outcome
  input  wire logic       clear_i,
  input  wire logic       event_i,
  input  wire logic       hit_i,
  input  wire logic       decr_i,
  input  wire logic [7:0] ref_i,
  output logic            reached_o
);
  import acs_pkg::*;

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] cnt_inc;
  logic       reached;

  // Reference zero bypasses the counter so the first match fires
  assign cnt_inc   = cnt_r + 8'd1;
  assign reached   = event_i & hit_i & ((ref_i == 8'h00) | (cnt_inc == ref_i));
  assign reached_o = reached;

  // Miss either steps down or restarts depending on decrement mode
  assign cnt_nxt = clear_i ? 8'h00 :
                   !event_i ? cnt_r :
                   reached ? 8'h00 :
                   hit_i ? cnt_inc :
                   (decr_i && cnt_r != 8'h00) ? (cnt_r - 8'd1) : 8'h00;

  // Counter register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // acs_match_counter

// ### acs_adc_sequencer.sv
// Conversion sequencer with control, status and result registers of the ADC
`timescale 1ns/1ps
module acs_adc_sequencer #(
  parameter int unsigned SETTLE_CYC = acs_pkg::SETTLE_CYC_DEF,
  parameter int unsigned BASE_CYC   = acs_pkg::BASE_CYC_DEF
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  // Register access port
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [7:0]                reg_rdata_o,
  // Converter core
  input  wire logic [9:0]                adc_data_i,
  input  wire logic                      cmp_hit_i,
  output logic      [acs_pkg::CHAN_W-1:0] channel_select_o,
  output logic                           sample_o,
  output logic                           convert_o,
  output logic                           busy_o
);
  import acs_pkg::*;

  // ==========================================================================
  // Declarations
  acs_state_type     state_r, state_nxt;
  logic              single_shot_start_r, repeat_start_r, rdy_r, cmpf_r;
  logic [CHAN_W-1:0] chan_r;
  logic [7:0]        conf_r, cmph_r, ref_r;
  logic [7:0]        res_hi_r, res_lo_r, shadow_r, rdata_r;
  logic              sample_r, convert_r, busy_r;
  logic [15:0]       phase_cyc_r;
  logic              hit_stat, hit_resh, hit_resl, hit_ctrl, hit_conf, hit_cmph, hit_ref;
  logic              wr_ctrl, wr_stat, first_rd, second_rd;
  logic              run_req, cont, is_temp, just_right, comparator_enable, hold_gate;
  logic [2:0]        sr;
  logic              tmr_zero, tmr_load, conv_done, rdy_set, rdy_clr, reached;
  logic [15:0]       tmr_len, smp_len, idl_len;
  logic [7:0]        fmt_hi, fmt_lo, stat_val, rd_mux;

  // ==========================================================================
  // Phase length: span of one result is base period times divisor
  function automatic logic [15:0] phase_len(input logic [2:0] code, input logic temp,
                                            input logic idle_ph);
    logic [2:0]  eff;
    int unsigned span;
    eff  = (temp && code < TEMP_MIN_SR) ? TEMP_MIN_SR : code;
    span = BASE_CYC << eff;
    if (idle_ph) begin
      phase_len = temp ? 16'(span - TSMP_CYC - CONV_CYC) : 16'(IDLE_CYC);
    end else begin
      phase_len = temp ? 16'(TSMP_CYC) : 16'(span - CONV_CYC - IDLE_CYC);
    end
  endfunction

  // ==========================================================================
  // Address decode and access strobes
  assign hit_stat   = (reg_addr_i == ADDR_STAT);
  assign hit_resh   = (reg_addr_i == ADDR_RESH);
  assign hit_resl   = (reg_addr_i == ADDR_RESL);
  assign hit_ctrl   = (reg_addr_i == ADDR_CTRL);
  assign hit_conf   = (reg_addr_i == ADDR_CONF);
  assign hit_cmph   = (reg_addr_i == ADDR_CMPH);
  assign hit_ref    = (reg_addr_i == ADDR_REF);
  assign wr_ctrl    = reg_wr_i & hit_ctrl;
  assign wr_stat    = reg_wr_i & hit_stat;
  assign just_right = conf_r[CONF_JUST_BIT];
  // Justification decides which read comes first: RESH when left justified, RESL when right justified
  assign first_rd   = reg_rd_i & (just_right ? hit_resl : hit_resh);
  assign second_rd  = reg_rd_i & (just_right ? hit_resh : hit_resl);

  // ==========================================================================
  // Mode decode
  assign run_req   = single_shot_start_r | repeat_start_r;
  assign cont      = repeat_start_r;
  assign sr        = conf_r[CONF_SR_LSB +: 3];
  assign is_temp   = (chan_r == TEMP_CHAN);
  assign comparator_enable     = cmph_r[CMPH_EN_BIT];
  // Hold mode parks while an unread result is pending
  assign hold_gate = repeat_start_r & conf_r[CONF_HOLD_BIT] & rdy_r;
  assign smp_len   = phase_len(sr, is_temp, 1'b0);
  assign idl_len   = phase_len(sr, is_temp, 1'b1);
  assign conv_done = (state_r == ST_CONV) & tmr_zero & run_req;

  // ==========================================================================
  // Sequencer next state and phase loads
  always_comb begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_len   = smp_len;
    if (!run_req) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_nxt = ST_SETTLE;
          tmr_load  = 1'b1;
          tmr_len   = 16'(SETTLE_CYC);
        end
        ST_SETTLE, ST_IDLEPH: begin
          if (tmr_zero) begin
            state_nxt = hold_gate ? ST_HOLD : ST_SAMPLE;
            tmr_load  = !hold_gate;
          end
        end
        ST_HOLD: begin
          if (!rdy_r) begin
            state_nxt = ST_SAMPLE;
            tmr_load  = 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (tmr_zero) begin
            state_nxt = ST_CONV;
            tmr_load  = 1'b1;
            tmr_len   = 16'(CONV_CYC);
          end
        end
        ST_CONV: begin
          if (tmr_zero) begin
            state_nxt = cont ? ST_IDLEPH : ST_IDLE;
            tmr_load  = cont;
            tmr_len   = idl_len;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Result formatting by justification
  assign fmt_hi = just_right ? {6'h00, adc_data_i[9:8]} : adc_data_i[9:2];
  assign fmt_lo = just_right ? adc_data_i[7:0] : {adc_data_i[1:0], 6'h00};

  // ==========================================================================
  // Flag events; a new result beats a clear in the same cycle
  assign rdy_set  = conv_done & ~comparator_enable;
  assign rdy_clr  = first_rd | (wr_stat & reg_wdata_i[STAT_RDY_BIT]);
  assign stat_val = {6'h00, cmpf_r, rdy_r};

  // ==========================================================================
  // Read data select; unmapped offsets read zero
  assign rd_mux = hit_stat ? stat_val :
                  first_rd ? (just_right ? res_lo_r : res_hi_r) :
                  second_rd ? shadow_r :
                  hit_ctrl ? {single_shot_start_r, repeat_start_r, 2'b00, chan_r} :
                  hit_conf ? {2'b00, conf_r[5:0]} :
                  hit_cmph ? cmph_r :
                  hit_ref ? ref_r : 8'h00;

  // ==========================================================================
  // Control registers; start bits cleared by reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      single_shot_start_r <= 1'b0;
      repeat_start_r <= 1'b0;
      chan_r <= CHAN_RST;
      conf_r <= CONF_RST;
    end else begin
      if (wr_ctrl) begin
        single_shot_start_r <= reg_wdata_i[CTRL_SINGLE_SHOT_START_BIT];
        repeat_start_r <= reg_wdata_i[CTRL_REPEAT_START_BIT];
        chan_r <= reg_wdata_i[CHAN_W-1:0];
      end else if (conv_done && !repeat_start_r) begin
        single_shot_start_r <= 1'b0;
      end
      if (reg_wr_i && hit_conf) begin
        conf_r <= {2'b00, reg_wdata_i[5:0]};
      end
    end
  end

  // Comparator setup is frozen while a conversion runs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmph_r <= CMPH_RST;
      ref_r  <= REF_RST;
    end else if (!busy_r) begin
      if (reg_wr_i && hit_cmph) begin
        cmph_r <= reg_wdata_i & CMPH_MASK;
      end
      if (reg_wr_i && hit_ref) begin
        ref_r <= reg_wdata_i;
      end
    end
  end

  // ==========================================================================
  // Status flags, set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdy_r  <= 1'b0;
      cmpf_r <= 1'b0;
    end else begin
      rdy_r  <= rdy_set | (rdy_r & ~rdy_clr);
      cmpf_r <= reached | (cmpf_r & ~(wr_stat & reg_wdata_i[STAT_CMP_BIT]));
    end
  end

  // ==========================================================================
  // Result registers; overwritten each conversion unless hold mode parks
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      res_hi_r <= 8'h00;
      res_lo_r <= 8'h00;
      shadow_r <= 8'h00;
    end else begin
      if (conv_done) begin
        res_hi_r <= fmt_hi;
        res_lo_r <= fmt_lo;
      end
      if (first_rd) begin
        shadow_r <= just_right ? res_hi_r : res_lo_r;
      end
    end
  end

  // ==========================================================================
  // State, read data and core strobes, all registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r   <= ST_IDLE;
      rdata_r   <= 8'h00;
      sample_r  <= 1'b0;
      convert_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      sample_r  <= (state_nxt == ST_SAMPLE);
      convert_r <= (state_nxt == ST_CONV);
      busy_r    <= (state_nxt != ST_IDLE);
      if (reg_rd_i) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign reg_rdata_o      = rdata_r;
  assign channel_select_o = chan_r;
  assign sample_o         = sample_r;
  assign convert_o        = convert_r;
  assign busy_o           = busy_r;

  // ==========================================================================
  // Sub blocks
  acs_phase_timer u_timer (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .load_i (tmr_load),
    .len_i  (tmr_len),
    .zero_o (tmr_zero)
  );

  acs_match_counter u_match (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .clear_i   (~comparator_enable),
    .event_i   (conv_done & comparator_enable),
    .hit_i     (cmp_hit_i),
    .decr_i    (cmph_r[CMPH_DEC_BIT]),
    .ref_i     (ref_r),
    .reached_o (reached)
  );

  // ==========================================================================
  // Checking: cycles spent in the current state
  always_ff @(posedge clk_i) begin
    if (srst_i || state_nxt != state_r) begin
      phase_cyc_r <= 16'd0;
    end else begin
      phase_cyc_r <= phase_cyc_r + 16'd1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_cmp_flag_set: assert property (conv_done && comparator_enable && cmp_hit_i && ref_r == 8'h00
    |=> cmpf_r) else $error("compare flag not set on first match");
  a_ready_on_done: assert property (conv_done && !comparator_enable |=> rdy_r && state_r != ST_CONV)
    else $error("ready flag missing after conversion");
  a_ready_masked: assert property (comparator_enable && !rdy_r |=> !rdy_r)
    else $error("ready flag rose while comparator enabled");
  a_stat_upper_zero: assert property (reg_rd_i && hit_stat |=> reg_rdata_o[7:2] == 6'h00)
    else $error("status upper bits not zero");
  a_settle_span: assert property (state_r == ST_SETTLE && state_nxt != ST_SETTLE && run_req
    |-> phase_cyc_r == 16'(SETTLE_CYC - 1)) else $error("settling period length wrong");
  a_conv_span: assert property (conv_done |-> phase_cyc_r == 16'(CONV_CYC - 1))
    else $error("conversion phase length wrong");
  a_start_settles: assert property (state_r == ST_IDLE && run_req |=> state_r == ST_SETTLE)
    else $error("start did not enter settling");
  a_single_clear: assert property (conv_done && !repeat_start_r && !wr_ctrl
    |=> !single_shot_start_r && (rdy_r || comparator_enable) && state_r == ST_IDLE) else $error("single shot not closed");
  a_hold_waits: assert property (state_r == ST_HOLD && rdy_r && run_req
    |=> state_r == ST_HOLD) else $error("hold mode resumed before read");
  a_read_clears: assert property (first_rd && !rdy_set |=> !rdy_r)
    else $error("result read did not clear ready");

  c_single_done: cover property (conv_done && !repeat_start_r);
  c_cont_two: cover property (conv_done && repeat_start_r ##[1:1000] conv_done);
  c_hold_park: cover property (state_r == ST_HOLD ##1 state_r == ST_SAMPLE);
  c_cmp_event: cover property (reached);

endmodule // acs_adc_sequencer

// ### acs_core_model.sv
// Behavioural stand-in for the converter core that feeds the sequencer
`timescale 1ns/1ps
module acs_core_model (
  // Sequencer phase
  input  wire logic       convert_i,
  // Values commanded by the bench
  input  wire logic [9:0] code_i,
  input  wire logic       hit_i,
  // Core outputs
  output logic      [9:0] adc_data_o,
  output logic            cmp_hit_o
);
  // ==========================================================================
  // Core outputs
  // Valid only while converting. Outside that window the inverse is shown,
  // so that a result taken at the wrong moment comes out wrong.
  assign adc_data_o = convert_i ? code_i : ~code_i;
  assign cmp_hit_o  = convert_i ? hit_i : ~hit_i;
endmodule // acs_core_model

// ### acs_adc_sequencer_bench.sv
// Self-checking bench for the ADC conversion sequencer
`timescale 1ns/1ps
module acs_adc_sequencer_bench;
  import acs_pkg::*;
  // Short settling so that the run stays brief
  localparam int unsigned SET_N  = 5;
  localparam int unsigned BASE_N = 101;
  // ==========================================================================
  // Signals
  logic              clk_i;
  logic              srst_i;
  logic [7:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [7:0]        reg_rdata_o;
  logic [9:0]        adc_data_i;
  logic              cmp_hit_i;
  logic [CHAN_W-1:0] channel_select_o;
  logic              sample_o;
  logic              convert_o;
  logic              busy_o;
  logic [9:0]        code_r;
  logic              hit_r;
  logic [7:0]        d;
  int                error_cnt;
  int                n_checks;
  int                n;

  // ==========================================================================
  // Design and core model
  acs_adc_sequencer #(.SETTLE_CYC(SET_N), .BASE_CYC(BASE_N)) acs_adc_sequencer_i (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .adc_data_i(adc_data_i), .cmp_hit_i(cmp_hit_i), .channel_select_o(channel_select_o),
    .sample_o(sample_o), .convert_o(convert_o), .busy_o(busy_o));
  acs_core_model acs_core_model_i (
    .convert_i(convert_o), .code_i(code_r), .hit_i(hit_r),
    .adc_data_o(adc_data_i), .cmp_hit_o(cmp_hit_i));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Tests need about 30k cycles; the limit leaves ample margin
  initial begin
    #2000000;
    error_cnt++;
    test_done();
  end

  // ==========================================================================
  // Checking and register access
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobes are one cycle wide and always followed by an idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    v = reg_rdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, {8'h00, v}, {8'h00, e});
  endtask

  // ==========================================================================
  // Phase measurement: 0 busy but neither sampling nor converting
  function automatic logic cond(input int s);
    case (s)
      0: return busy_o === 1'b1 && sample_o === 1'b0 && convert_o === 1'b0;
      1: return sample_o === 1'b1;
      default: return convert_o === 1'b1;
    endcase
  endfunction
  task automatic cnt(input int s, output int k);
    int g;
    g = 0;
    k = 0;
    while (!cond(s) && g < 4000) begin
      @(negedge clk_i);
      g++;
    end
    while (cond(s) && k < 14000) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  // Phase lengths: sample, convert and idle together make one rate period
  function automatic int smp_len(input logic [3:0] ch, input int sr);
    return (ch == TEMP_CHAN) ? TSMP_CYC : BASE_N * (1 << sr) - CONV_CYC - IDLE_CYC;
  endfunction
  function automatic int idl_len(input logic [3:0] ch, input int sr);
    return (ch == TEMP_CHAN) ? BASE_N * (1 << (sr < 3 ? 3 : sr)) - TSMP_CYC - CONV_CYC
                             : IDLE_CYC;
  endfunction
  task automatic conv(input logic [7:0] ctl, input int sr, input logic [7:0] cf);
    wr(ADDR_CONF, cf | 8'(sr));
    wr(ADDR_CTRL, ctl);
    chk("channel", 16'(channel_select_o), 16'(ctl[3:0]));
    cnt(0, n);
    chk("settle", 16'(n), 16'(SET_N));
    cnt(1, n);
    chk("sample", 16'(n), 16'(smp_len(ctl[3:0], sr)));
    cnt(2, n);
    chk("convert", 16'(n), 16'(CONV_CYC));
  endtask
  task automatic stop;
    int g;
    wr(ADDR_CTRL, 8'h00);
    g = 0;
    while (busy_o !== 1'b0 && g < 20) begin
      @(negedge clk_i);
      g++;
    end
    chk("stopped", {15'h0, busy_o}, 16'h0000);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    error_cnt = 0;
    n_checks = 0;
    srst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    code_r = 10'h000;
    hit_r = 1'b0;
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    // Reset values, unused status bits and an unmapped place
    rchk(ADDR_STAT, 8'h00, "status");
    rchk(ADDR_CTRL, 8'h00, "control");
    rchk(ADDR_CONF, CONF_RST, "config");
    rchk(ADDR_CMPH, CMPH_RST, "cmp ctrl");
    wr(8'h20, 8'hff);
    rchk(8'h20, 8'h00, "unmapped");
    $display("test reset done");
    // Single shots at every rate code, left justified
    for (int sr = 0; sr < 8; sr++) begin
      code_r = 10'h2d7 ^ 10'(sr * 9);
      conv(8'h80 | 8'(sr), sr, 8'h00);
      chk("single end", {15'h0, busy_o}, 16'h0000);
      rchk(ADDR_STAT, 8'h01, "ready");
      rchk(ADDR_CTRL, 8'(sr), "start clear");
      rchk(ADDR_RESH, code_r[9:2], "high");
      rchk(ADDR_STAT, 8'h00, "ready read");
      rchk(ADDR_RESL, {code_r[1:0], 6'h00}, "low");
    end
    $display("test single done");
    // Right justified, then clearing ready by writing one
    code_r = 10'h19c;
    conv(8'h85, 0, 8'h20);
    rchk(ADDR_RESL, code_r[7:0], "right low");
    rchk(ADDR_STAT, 8'h00, "right ready");
    rchk(ADDR_RESH, {6'h00, code_r[9:8]}, "right high");
    conv(8'h85, 0, 8'h20);
    wr(ADDR_STAT, 8'h01);
    rchk(ADDR_STAT, 8'h00, "w1c ready");
    $display("test justify done");
    // Temperature channel in continuous mode, both start bits set
    for (int sr = 1; sr < 5; sr += 3) begin
      conv(8'hcf, sr, 8'h00);
      cnt(0, n);
      chk("temp idle", 16'(n), 16'(idl_len(TEMP_CHAN, sr)));
      cnt(1, n);
      chk("temp again", 16'(n), 16'(TSMP_CYC));
      stop();
    end
    // Continuous without hold: an unread result is overwritten
    code_r = 10'h2a6;
    conv(8'hc1, 0, 8'h00);
    code_r = 10'h0f3;
    cnt(0, n);
    chk("idle", 16'(n), 16'(IDLE_CYC));
    cnt(1, n);
    chk("repeat", 16'(n), 16'(smp_len(4'h1, 0)));
    cnt(2, n);
    rchk(ADDR_STAT, 8'h01, "cont ready");
    rchk(ADDR_RESH, code_r[9:2], "overwrite");
    stop();
    $display("test continuous done");
    // Hold mode: halt until the result is read
    rd(ADDR_RESH, d);
    code_r = 10'h155;
    conv(8'hc2, 0, 8'h08);
    n = 0;
    repeat (200) begin
      @(negedge clk_i);
      if (sample_o !== 1'b0) n++;
    end
    chk("halted", 16'(n), 16'h0000);
    rchk(ADDR_RESH, code_r[9:2], "hold high");
    cnt(1, n);
    chk("resume", 16'(n), 16'(smp_len(4'h2, 0)));
    cnt(2, n);
    rchk(ADDR_STAT, 8'h01, "hold ready");
    stop();
    $display("test hold done");
    // Comparator: match counting, masked ready, locked while busy
    rd(ADDR_RESH, d);
    wr(ADDR_CMPH, 8'h80);
    wr(ADDR_REF, 8'h02);
    hit_r = 1'b1;
    conv(8'hc1, 0, 8'h00);
    rchk(ADDR_STAT, 8'h00, "cmp first");
    wr(ADDR_CMPH, 8'h00);
    rchk(ADDR_CMPH, 8'h80, "cmp lock");
    cnt(2, n);
    rchk(ADDR_STAT, 8'h02, "cmp flag");
    wr(ADDR_STAT, 8'h02);
    rchk(ADDR_STAT, 8'h00, "w1c cmp");
    stop();
    // Reference zero: the first match raises the flag at once
    wr(ADDR_REF, 8'h00);
    conv(8'h81, 0, 8'h00);
    rchk(ADDR_STAT, 8'h02, "cmp bypass");
    wr(ADDR_STAT, 8'h02);
    // Decrement on a miss: hit hit miss hit hit reaches three
    wr(ADDR_CMPH, 8'ha0);
    wr(ADDR_REF, 8'h03);
    for (int i = 0; i < 5; i++) begin
      hit_r = (i != 2);
      conv(8'h81, 0, 8'h00);
    end
    rchk(ADDR_STAT, 8'h02, "cmp decrement");
    wr(ADDR_STAT, 8'h02);
    wr(ADDR_CMPH, 8'h00);
    $display("test comparator done");
    // Reset in mid run: back to idle with both starts cleared
    conv(8'hc1, 0, 8'h00);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    chk("reset busy", {15'h0, busy_o}, 16'h0000);
    rchk(ADDR_CTRL, 8'h00, "reset control");
    rchk(ADDR_STAT, 8'h00, "reset status");
    $display("test reset run done");
    test_done();
  end
endmodule // acs_adc_sequencer_bench
